// file: ies_selector.sv
// ies_selector.sv: interrupt event selector, sixteen prioritized core lines behind APB
// assumes synchronous event inputs and an APB master on pclk
`timescale 1ns/10ps
`include "ies_regs.svh"
module ies_selector
    import ies_pkg::*;
(
    input wire logic pclk, // 50 MHz system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic reset_event, // device reset request
    input wire logic nmi_event, // non-maskable interrupt
    input wire ies_events_type events, // peripheral events
    output logic [15:0] core_int_q, // lines to core, bit n is line n
    output logic irq_q // summary interrupt, level
);
    typedef struct packed {
        logic [31:0] sel_high;
        logic [31:0] sel_low;
        logic [11:0] status;
        logic [11:0] mask;
        logic [3:0] fixed;
        ies_apb_out_type apb;
        logic irq;
    } ies_state_type;

    ies_state_type s_q;
    ies_state_type s_d;
    logic [11:0] routed;
    logic [11:0] routed_prev_q;
    logic [11:0] rise;
    logic acc;
    logic wr;

    // one router per maskable line; fields sit at the same six positions in both registers
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++) begin : g_line
            localparam int FI = gi % 6;
            localparam int LSB = (FI == 0) ? `IES_FIELD_LSB0 : (FI == 1) ? `IES_FIELD_LSB1 :
                (FI == 2) ? `IES_FIELD_LSB2 : (FI == 3) ? `IES_FIELD_LSB3 :
                (FI == 4) ? `IES_FIELD_LSB4 : `IES_FIELD_LSB5;
            ies_code_type code;
            // lines 4..9 from low register, 10..15 from high
            assign code = (gi < 6) ? s_q.sel_low[LSB +: `IES_FIELD_W]
                                   : s_q.sel_high[LSB +: `IES_FIELD_W];
            ies_route u_route (
                .pclk(pclk),
                .presetn(presetn),
                .code(code),
                .ev(events),
                .line_q(routed[gi])
            );
        end
    endgenerate

    // edge history for sticky status, so a held level counts once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            routed_prev_q <= '0;
        end else begin
            routed_prev_q <= routed;
        end
    end
    assign rise = routed & ~routed_prev_q;

    assign acc = psel && penable;
    assign wr = acc && pwrite;

    // register file, status, fixed lines; answers every access in its first access cycle
    always_comb begin
        s_d = s_q;
        s_d.apb.pready = 1'b0;
        s_d.apb.pslverr = 1'b0;
        // lines 0..1 carry reset and nmi, lines 2..3 held low; never selectable
        s_d.fixed = {2'b00, nmi_event, reset_event};
        if (psel && !penable) begin
            s_d.apb.pready = 1'b1;
            s_d.apb.prdata = '0;
            case (paddr)
                `IES_SEL_HIGH_OFS: s_d.apb.prdata = s_q.sel_high;
                `IES_SEL_LOW_OFS: s_d.apb.prdata = s_q.sel_low;
                `IES_STATUS_OFS: s_d.apb.prdata = {20'h00000, s_q.status};
                `IES_MASK_OFS: s_d.apb.prdata = {20'h00000, s_q.mask};
                default: s_d.apb.pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            case (paddr)
                `IES_SEL_HIGH_OFS: s_d.sel_high = pwdata & `IES_SEL_VALID_MASK;
                `IES_SEL_LOW_OFS: s_d.sel_low = pwdata & `IES_SEL_VALID_MASK;
                `IES_STATUS_OFS: s_d.status = s_q.status & ~pwdata[11:0];
                `IES_MASK_OFS: s_d.mask = pwdata[11:0];
                default: ;
            endcase
        end
        // set wins over a write-one clear in the same cycle
        s_d.status = s_d.status | rise;
        s_d.irq = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.sel_high <= `IES_SEL_HIGH_RST;
            s_q.sel_low <= `IES_SEL_LOW_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // line n is bit n: position fixes priority, 0 highest, 15 lowest
    assign core_int_q = {routed, s_q.fixed};
    assign irq_q = s_q.irq;
    assign prdata = s_q.apb.prdata;
    assign pready = s_q.apb.pready;
    assign pslverr = s_q.apb.pslverr;

    // defaults after reset: line 4 takes pin 4, line 14 timer0
    reset_codes_a: assert property (@(posedge pclk) $rose(presetn) |->
        s_q.sel_low[4:0] == 5'h04 && s_q.sel_high[25:21] == 5'h01)
        else $error("selector reset codes wrong");
    reset_high_a: assert property (@(posedge pclk) $rose(presetn) |->
        s_q.sel_high[4:0] == 5'h03 && s_q.sel_high[20:16] == 5'h00)
        else $error("high selector reset codes wrong");
    // timer0 event on a line coded 00001 shows one cycle later
    timer_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        events.timer0 && s_q.sel_high[25:21] == 5'h01 |=> core_int_q[14])
        else $error("timer0 not routed");
    pin_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        events.ext_pin[0] && s_q.sel_low[4:0] == 5'h04 |=> core_int_q[4])
        else $error("pin 4 not routed");
    dma_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        events.dma_done && s_q.sel_low[25:21] == 5'h08 |=> core_int_q[8])
        else $error("dma not routed");
    serial_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        events.ser1_rx && s_q.sel_high[30:26] == 5'h0f |=> core_int_q[15])
        else $error("serial rx not routed");
    idle_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.sel_high[20:16] == 5'h00 |=> !core_int_q[13])
        else $error("empty code drove a line");
    fixed_line_a: assert property (@(posedge pclk) disable iff (!presetn)
        nmi_event |=> core_int_q[1] && !core_int_q[2] && !core_int_q[3])
        else $error("fixed lines wrong");
    sel_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `IES_SEL_LOW_OFS |=> s_q.sel_low == ($past(pwdata) & `IES_SEL_VALID_MASK))
        else $error("low selector write lost");
    status_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        rise[0] |=> s_q.status[0] ##1 (s_q.status[0] || $past(wr) && $past(paddr) == `IES_STATUS_OFS))
        else $error("status bit not sticky");
endmodule : ies_selector

// file: ies_regs.svh
// ies_regs.svh: register offsets, field positions, reset values of the interrupt event selector
// assumes an APB slave decoding the full 32-bit byte address of a word map
`ifndef IES_REGS_SVH
`define IES_REGS_SVH

`define IES_SEL_HIGH_OFS 32'h019c0000
`define IES_SEL_LOW_OFS 32'h019c0004
`define IES_STATUS_OFS 32'h019c0008
`define IES_MASK_OFS 32'h019c000c
`define IES_FIELD_W 5
`define IES_FIELD_LSB0 0
`define IES_FIELD_LSB1 5
`define IES_FIELD_LSB2 10
`define IES_FIELD_LSB3 16
`define IES_FIELD_LSB4 21
`define IES_FIELD_LSB5 26
`define IES_SEL_LOW_RST 32'h250718a4
`define IES_SEL_HIGH_RST 32'h08202d43
`define IES_SEL_VALID_MASK 32'h7fff7fff
`define IES_CODE_TIMER0 5'h01
`define IES_CODE_TIMER1 5'h02
`define IES_CODE_SDRAM 5'h03
`define IES_CODE_PIN4 5'h04
`define IES_CODE_DMA 5'h08
`define IES_CODE_SER0_TX 5'h0c
`define IES_CODE_SER0_RX 5'h0d
`define IES_CODE_SER1_TX 5'h0e
`define IES_CODE_SER1_RX 5'h0f

`endif

// file: ies_pkg.sv
// ies_pkg.sv: types shared by the interrupt event selector
// assumes ies_regs.svh is compiled alongside
package ies_pkg;
    typedef logic [4:0] ies_code_type;

    // raw peripheral event sources, one bit each
    typedef struct packed {
        logic [3:0] ext_pin;   // pins 7..4 at bits 3..0
        logic dma_done;
        logic sdram_refresh;
        logic timer0;
        logic timer1;
        logic ser0_tx;
        logic ser0_rx;
        logic ser1_tx;
        logic ser1_rx;
    } ies_events_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ies_apb_out_type;
endpackage : ies_pkg

// file: ies_route.sv
// ies_route.sv: one selected line; decodes a selector code to its event source
// assumes events are synchronous one-clock levels or pulses
`timescale 1ns/10ps
`include "ies_regs.svh"
module ies_route
    import ies_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire ies_code_type code, // selector field for this line
    input wire ies_events_type ev, // all event sources
    output logic line_q // registered line level
);
    typedef struct packed {
        logic line;
    } ies_route_state_type;

    ies_route_state_type s_q;
    ies_route_state_type s_d;
    logic hit;

    // code decode; unused and reserved codes give no source
    always_comb begin
        case (code)
            `IES_CODE_TIMER0: hit = ev.timer0;
            `IES_CODE_TIMER1: hit = ev.timer1;
            `IES_CODE_SDRAM: hit = ev.sdram_refresh;
            5'h04, 5'h05, 5'h06, 5'h07: hit = ev.ext_pin[code[1:0]];
            `IES_CODE_DMA: hit = ev.dma_done;
            `IES_CODE_SER0_TX: hit = ev.ser0_tx;
            `IES_CODE_SER0_RX: hit = ev.ser0_rx;
            `IES_CODE_SER1_TX: hit = ev.ser1_tx;
            `IES_CODE_SER1_RX: hit = ev.ser1_rx;
            default: hit = 1'b0;
        endcase
        s_d.line = hit;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign line_q = s_q.line;
endmodule : ies_route

// file: ies_partner.sv
// ies_partner.sv: event sources and reset/nmi requests facing the selector
// assumes the bench hands over a wanted pattern; it shows one edge later
`timescale 1ns/10ps
module ies_partner
    import ies_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic [13:0] want, // reset, nmi, then events
    output logic reset_event, // reset request
    output logic nmi_event, // nmi request
    output ies_events_type events // peripheral events
);
    // sources are synchronous, so changes land just after the edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {reset_event, nmi_event, events} <= 14'h0000;
        end else begin
            {reset_event, nmi_event, events} <= want;
        end
    end
endmodule : ies_partner

// file: test_interrupt_event_selector.sv
// test_interrupt_event_selector.sv: self-checking bench for the event selector
// assumes ies_partner drives the sources and the bench is the apb master
`timescale 1ns/10ps
`include "ies_regs.svh"
module test_interrupt_event_selector
    import ies_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, reset_event, nmi_event, irq_q;
    logic [13:0] want = 14'h0000;
    logic [15:0] core_int_q;
    ies_events_type events;
    logic [4:0] codes [4:15];
    localparam logic [4:0] def_codes [4:15] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
        5'h03, 5'h0a, 5'h0b, 5'h00, 5'h01, 5'h02};
    int bad_count = 0, samples_checked = 0, seed = 59;
    // free-running 50 MHz clock
    always #10 pclk = ~pclk;
    ies_partner src(.pclk(pclk), .presetn(presetn), .want(want), .reset_event(reset_event),
        .nmi_event(nmi_event), .events(events));
    ies_selector dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_event(reset_event), .nmi_event(nmi_event), .events(events),
        .core_int_q(core_int_q), .irq_q(irq_q));
    // source picked by one selector code
    function automatic logic route(logic [4:0] c, ies_events_type e);
        case (c)
            5'h01: return e.timer0;
            5'h02: return e.timer1;
            5'h03: return e.sdram_refresh;
            5'h04, 5'h05, 5'h06, 5'h07: return e.ext_pin[c[1:0]];
            5'h08: return e.dma_done;
            5'h0c: return e.ser0_tx;
            5'h0d: return e.ser0_rx;
            5'h0e: return e.ser1_tx;
            5'h0f: return e.ser1_rx;
            default: return 1'b0;
        endcase
    endfunction : route
    // six fields, gap at bit 15
    function automatic logic [31:0] pack(int base);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 6; i++) begin
            r[i * 5 + (i > 2 ? 1 : 0) +: 5] = codes[base + i];
        end
        return r;
    endfunction : pack
    function automatic logic [15:0] lines();
        logic [15:0] r;
        r = {14'h0000, want[12], want[13]};
        for (int n = 4; n < 16; n++) begin
            r[n] = route(codes[n], want[11:0]);
        end
        return r;
    endfunction : lines
    task automatic tick(int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %0t seen %h wanted %h", $time, seen, exp);
        end
    endtask : check
    // one transfer; waits for pready under a bounded count
    task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            $display("unexpected %0t no pready", $time);
            bad_count++;
            summarize();
        end
    endtask : apb
    task automatic prog();
        apb(1'b1, `IES_SEL_HIGH_OFS, pack(10), rd, err);
        apb(1'b1, `IES_SEL_LOW_OFS, pack(4), rd, err);
    endtask : prog
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        bad_count++;
        summarize();
    end
    // main sequence
    initial begin
        codes = def_codes;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `IES_SEL_HIGH_OFS, 32'h0, rd, err);
        check(rd, pack(10));
        apb(1'b0, `IES_SEL_LOW_OFS, 32'h0, rd, err);
        check(rd, pack(4));
        apb(1'b0, 32'h019c0010, 32'h0, rd, err);
        check({rd[31:1], err}, 32'h1);
        want <= 14'h3fff;
        tick(3);
        check({16'h0, core_int_q}, {16'h0, lines()});
        $display("test defaults done");
        // codes 0..15 on every line first, then random codes below the reserved range
        for (int i = 0; i < 28; i++) begin
            for (int n = 4; n < 16; n++) begin
                codes[n] = (i < 16) ? 5'((i + n) % 16) : 5'($random(seed)) & 5'h0f;
            end
            prog();
            want <= 14'($random(seed));
            tick(3);
            check({16'h0, core_int_q}, {16'h0, lines()});
        end
        apb(1'b1, `IES_SEL_LOW_OFS, 32'hffffffff, rd, err);
        apb(1'b0, `IES_SEL_LOW_OFS, 32'h0, rd, err);
        check(rd, 32'h7fff7fff);
        $display("test routing done");
        want <= 14'h0000;
        codes = def_codes;
        prog();
        tick(3);
        apb(1'b1, `IES_STATUS_OFS, 32'hfff, rd, err);
        apb(1'b1, `IES_MASK_OFS, 32'h0, rd, err);
        apb(1'b0, `IES_STATUS_OFS, 32'h0, rd, err);
        check(rd, 32'h0);
        want <= 14'h0020;
        tick(4);
        apb(1'b0, `IES_STATUS_OFS, 32'h0, rd, err);
        check(rd, 32'h400);
        check({31'h0, irq_q}, 32'h0);
        apb(1'b1, `IES_MASK_OFS, 32'h400, rd, err);
        tick(2);
        check({31'h0, irq_q}, 32'h1);
        want <= 14'h0000;
        apb(1'b1, `IES_STATUS_OFS, 32'h400, rd, err);
        tick(2);
        check({31'h0, irq_q}, 32'h0);
        $display("test interrupt done");
        summarize();
    end
endmodule : test_interrupt_event_selector
